// [include/cpuxb_map.svh]
`ifndef CPUXB_MAP_SVH
`define CPUXB_MAP_SVH
// apb register offsets
`define CPUXB_OFS_CMD     8'h00
`define CPUXB_OFS_STAT    8'h04
`define CPUXB_OFS_FLAGS   8'h08
`define CPUXB_OFS_PTR     8'h0c
`define CPUXB_OFS_CTRL    8'h10
`define CPUXB_OFS_GPR     8'h40
`define CPUXB_OFS_GPR_END 8'h7c
// command word fields
`define CPUXB_CMD_OP_LSB   0
`define CPUXB_CMD_BIT_LSB  5
`define CPUXB_CMD_REG_LSB  8
`define CPUXB_CMD_ADDR_LSB 12
// pointer register fields
`define CPUXB_PTR_Z_LSB  0
`define CPUXB_PTR_SP_LSB 8
// status register flag positions
`define CPUXB_FLG_C 0
`define CPUXB_FLG_Z 1
`define CPUXB_FLG_N 2
`define CPUXB_FLG_V 3
`define CPUXB_FLG_S 4
`define CPUXB_FLG_H 5
`define CPUXB_FLG_T 6
// reset values
`define CPUXB_FLAGS_RST 8'h00
`define CPUXB_SP_RST   8'hff
`define CPUXB_Z_RST    8'h00
`define CPUXB_WAIT_RST 2'h0
// execution lengths in cycles
`define CPUXB_CYC_ONE 4'h1
`define CPUXB_CYC_TWO 4'h2
`endif

// [include/cpuxb_pkg.sv]
`default_nettype none
package cpuxb_pkg;
   typedef enum logic [4:0] {
      OP_NOP, OP_IO_READ, OP_IO_WRITE, OP_PUSH, OP_POP,
      OP_EXCHG, OP_LD_OR, OP_LD_ANDN, OP_LD_XOR,
      OP_LSL, OP_LSR, OP_ROT_L, OP_ROT_R, OP_ASR, OP_SWAP,
      OP_FSET, OP_FCLR, OP_IOB_SET, OP_IOB_CLR, OP_T_STORE, OP_T_LOAD,
      OP_BREAK, OP_SLEEP, OP_WDR
   } cpuxb_op_t;
   typedef enum logic {ST_IDLE, ST_EXEC} cpuxb_state_t;
   typedef logic [7:0] cpuxb_byte_t;
endpackage
`default_nettype wire

// [include/cpuxb_mem_if.sv]
`default_nettype none
interface cpuxb_mem_if;
   logic       ce;
   logic       we;
   logic [7:0] waddr;
   logic [7:0] wdata;
   logic [7:0] raddr;
   logic [7:0] rdata;
   modport core (output ce, we, waddr, wdata, raddr, input rdata);
   modport mem  (input ce, we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// [logic/cpuxb_dmem.sv]
`default_nettype none
module cpuxb_dmem
   import cpuxb_pkg::*;
(
   // clock
   input wire logic  clk,
   // data memory port
   cpuxb_mem_if.mem  port
);
   cpuxb_byte_t ram_q [256];
   cpuxb_byte_t rdata_q;

   // read returns the old byte on a same-address write
   always_ff @(posedge clk)
   begin
      if (port.ce)
      begin
         if (port.we)
            ram_q[port.waddr] <= port.wdata;
         rdata_q <= ram_q[port.raddr];
      end
   end

   assign port.rdata = rdata_q;
endmodule // cpuxb_dmem
`default_nettype wire

// [logic/cpuxb_core.sv]
// Function
// - io read copies I/O byte into register in one cycle, flags kept
// - push writes register onto stack in one cycle, flags kept
// - pop loads register from stack in two cycles, flags kept
// - load-or returns old byte, writes register OR byte, two cycles
// - load-andnot returns old byte, writes byte AND NOT register
// - load-xor returns old byte, writes register XOR byte, two cycles
// - rotate left through carry, one cycle, updates Z C N V H
// - rotate right through carry, one cycle, updates Z C N V not H
// - io bit set forces selected I/O bit high in one cycle
// - io bit clear forces selected I/O bit low in one cycle
// - register bit copied into transfer flag in one cycle
// - transfer flag copied into register bit, flags kept
// - overflow flag set or cleared alone in one cycle
// - half carry flag set or cleared alone in one cycle
// - signed test flag set or cleared alone in one cycle
// - stack and memory cycle counts hold for internal memory only
//
// Added by the designer: the APB slave port and the register offsets.
`include "cpuxb_map.svh"
`default_nettype none
module cpuxb_core
   import cpuxb_pkg::*;
(
   // clocking
   input  wire logic        CLOCK,
   input  wire logic        SRST,
   input  wire logic        CLKEN,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // mcu control events
   output var  logic        BREAK_EVT,
   output var  logic        SLEEP_REQ,
   output var  logic        WDOG_CLR,
   output logic             BUSY
);
   cpuxb_mem_if mem_if ();

   cpuxb_state_t state_q;
   cpuxb_op_t    op_q;
   cpuxb_byte_t  gpr_q [16];
   cpuxb_byte_t  flags_q, flags_d;
   cpuxb_byte_t  sp_q, sp_d;
   cpuxb_byte_t  z_q;
   cpuxb_byte_t  addr_q;
   logic [2:0]   bit_q;
   logic [3:0]   rd_q;
   logic [3:0]   step_q;
   logic [3:0]   len_q;
   logic         first_q;
   logic [1:0]   wait_q;
   logic [31:0]  cmd_q;
   logic         rdy_q;
   logic         gpr_we;
   cpuxb_byte_t  gpr_wd;
   logic [8:0]   sh_res;

   // op length; memory ops stretch by the external wait count
   function automatic logic [3:0] op_len(cpuxb_op_t op, logic [1:0] ws);
      logic [3:0] base;
      logic       memop;
      base  = (op == OP_POP || op == OP_EXCHG || op == OP_LD_OR || op == OP_LD_ANDN ||
               op == OP_LD_XOR) ? `CPUXB_CYC_TWO : `CPUXB_CYC_ONE;
      memop = (op == OP_PUSH || op == OP_POP || op == OP_EXCHG || op == OP_LD_OR ||
               op == OP_LD_ANDN || op == OP_LD_XOR);
      return memop ? base + {2'h0, ws} : base;
   endfunction

   // {carry, result} of a one-bit shift or rotate
   function automatic logic [8:0] shift(cpuxb_op_t op, cpuxb_byte_t v, logic c);
      case (op)
         OP_LSL:  return {v[7], v[6:0], 1'b0};
         OP_LSR:  return {v[0], 1'b0, v[7:1]};
         OP_ROT_L: return {v[7], v[6:0], c};
         OP_ROT_R: return {v[0], c, v[7:1]};
         default: return {v[0], v[7], v[7:1]};
      endcase
   endfunction

   // apb decode
   wire         apb_acc   = PSEL && PENABLE && PREADY;
   wire         apb_wr    = apb_acc && PWRITE;
   wire         busy      = (state_q == ST_EXEC);
   wire         hit_cmd   = (PADDR == `CPUXB_OFS_CMD);
   wire         hit_stat  = (PADDR == `CPUXB_OFS_STAT);
   wire         hit_flags = (PADDR == `CPUXB_OFS_FLAGS);
   wire         hit_ptr   = (PADDR == `CPUXB_OFS_PTR);
   wire         hit_ctrl  = (PADDR == `CPUXB_OFS_CTRL);
   wire         hit_gpr   = (PADDR >= `CPUXB_OFS_GPR) && (PADDR <= `CPUXB_OFS_GPR_END)
                            && (PADDR[1:0] == 2'h0);
   wire [3:0]   gpr_idx   = PADDR[5:2];
   wire         hit_any   = hit_cmd || hit_stat || hit_flags || hit_ptr || hit_ctrl || hit_gpr;
   // command, flags, pointer and register writes are refused while an op runs; ctrl writes are still taken
   wire         wr_blk    = busy && (hit_cmd || hit_flags || hit_ptr || hit_gpr);
   wire         wr_ok     = apb_wr && !wr_blk && hit_any;
   wire         acc_go    = wr_ok && hit_cmd;
   wire         exec_go   = busy && first_q && CLKEN;
   cpuxb_op_t   cmd_op;
   assign       cmd_op    = cpuxb_op_t'(PWDATA[`CPUXB_CMD_OP_LSB +: 5]);
   wire [3:0]   cmd_reg   = PWDATA[`CPUXB_CMD_REG_LSB +: 4];
   wire [7:0]   cmd_addr  = PWDATA[`CPUXB_CMD_ADDR_LSB +: 8];
   wire [7:0]   eff_addr  = (cmd_op == OP_PUSH) ? sp_q :
                            (cmd_op == OP_POP) ? 8'(sp_q + 8'h01) :
                            (cmd_op == OP_EXCHG || cmd_op == OP_LD_OR || cmd_op == OP_LD_ANDN ||
                             cmd_op == OP_LD_XOR) ? z_q : cmd_addr;
   wire [7:0]   bmask     = 8'h01 << bit_q;
   cpuxb_byte_t rv;
   assign       rv        = gpr_q[rd_q];
   wire [7:0]   md        = mem_if.rdata;

   assign PREADY  = rdy_q && CLKEN;
   assign PSLVERR = PSEL && PENABLE && (!hit_any || (PWRITE && wr_blk));
   assign BUSY    = busy;

   // memory port: read at accept, write in the work cycle
   assign mem_if.ce    = CLKEN;
   assign mem_if.raddr = eff_addr;
   assign mem_if.waddr = addr_q;
   assign sh_res       = shift(op_q, rv, flags_q[`CPUXB_FLG_C]);
   always_comb
   begin
      mem_if.we    = 1'b0;
      mem_if.wdata = 8'h00;
      gpr_we       = 1'b0;
      gpr_wd       = rv;
      flags_d      = flags_q;
      sp_d         = sp_q;
      if (exec_go)
      begin
         case (op_q)
            OP_IO_READ:
            begin
               gpr_we = 1'b1;
               gpr_wd = md;
            end
            OP_IO_WRITE:
            begin
               mem_if.we    = 1'b1;
               mem_if.wdata = rv;
            end
            OP_PUSH:
            begin
               mem_if.we    = 1'b1;
               mem_if.wdata = rv;
               sp_d         = 8'(sp_q - 8'h01);
            end
            OP_POP:
            begin
               gpr_we = 1'b1;
               gpr_wd = md;
               sp_d   = 8'(sp_q + 8'h01);
            end
            OP_EXCHG, OP_LD_OR, OP_LD_ANDN, OP_LD_XOR:
            begin
               gpr_we    = 1'b1;
               gpr_wd    = md;
               mem_if.we = 1'b1;
               case (op_q)
                  OP_EXCHG:   mem_if.wdata = rv;
                  OP_LD_OR:   mem_if.wdata = rv | md;
                  OP_LD_ANDN: mem_if.wdata = md & ~rv;
                  default:    mem_if.wdata = rv ^ md;
               endcase
            end
            OP_LSL, OP_LSR, OP_ROT_L, OP_ROT_R, OP_ASR:
            begin
               gpr_we = 1'b1;
               gpr_wd = sh_res[7:0];
               flags_d[`CPUXB_FLG_C] = sh_res[8];
               flags_d[`CPUXB_FLG_Z] = (sh_res[7:0] == 8'h00);
               flags_d[`CPUXB_FLG_N] = sh_res[7];
               flags_d[`CPUXB_FLG_V] = sh_res[7] ^ sh_res[8];
               // half carry only for left moves
               if (op_q == OP_LSL || op_q == OP_ROT_L)
                  flags_d[`CPUXB_FLG_H] = rv[3];
            end
            OP_SWAP:
            begin
               gpr_we = 1'b1;
               gpr_wd = {rv[3:0], rv[7:4]};
            end
            OP_FSET: flags_d = flags_q | bmask;
            OP_FCLR: flags_d = flags_q & ~bmask;
            OP_IOB_SET, OP_IOB_CLR:
            begin
               mem_if.we    = 1'b1;
               mem_if.wdata = (op_q == OP_IOB_SET) ? (md | bmask) : (md & ~bmask);
            end
            OP_T_STORE: flags_d[`CPUXB_FLG_T] = rv[bit_q];
            OP_T_LOAD:
            begin
               gpr_we         = 1'b1;
               gpr_wd[bit_q]  = flags_q[`CPUXB_FLG_T];
            end
            default: ;
         endcase
      end
   end

   // sequencing and apb-side registers
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         state_q <= ST_IDLE;
         op_q    <= OP_NOP;
         first_q <= 1'b0;
         step_q  <= 4'h0;
         len_q   <= 4'h0;
         rd_q    <= 4'h0;
         bit_q   <= 3'h0;
         addr_q  <= 8'h00;
         cmd_q   <= 32'h0;
         rdy_q   <= 1'b0;
         PRDATA  <= 32'h0;
      end
      else if (CLKEN)
      begin
         rdy_q   <= PSEL && !(PENABLE && PREADY);
         first_q <= acc_go;
         if (PSEL && !PENABLE)
         begin
            if (hit_cmd)       PRDATA <= cmd_q;
            else if (hit_stat) PRDATA <= {20'h0, len_q, 7'h0, busy};
            else if (hit_flags) PRDATA <= {24'h0, flags_q};
            else if (hit_ptr)  PRDATA <= {16'h0, sp_q, z_q};
            else if (hit_ctrl) PRDATA <= {30'h0, wait_q};
            else if (hit_gpr)  PRDATA <= {24'h0, gpr_q[gpr_idx]};
            else               PRDATA <= 32'h0;
         end
         if (acc_go)
         begin
            state_q <= ST_EXEC;
            op_q    <= cmd_op;
            rd_q    <= cmd_reg;
            bit_q   <= PWDATA[`CPUXB_CMD_BIT_LSB +: 3];
            addr_q  <= eff_addr;
            cmd_q   <= PWDATA;
            len_q   <= op_len(cmd_op, wait_q);
            step_q  <= 4'(op_len(cmd_op, wait_q) - 4'h1);
         end
         else if (busy)
         begin
            if (step_q == 4'h0)
               state_q <= ST_IDLE;
            else
               step_q <= 4'(step_q - 4'h1);
         end
      end
   end

   // architectural state
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         flags_q   <= `CPUXB_FLAGS_RST;
         sp_q      <= `CPUXB_SP_RST;
         z_q       <= `CPUXB_Z_RST;
         wait_q    <= `CPUXB_WAIT_RST;
         BREAK_EVT <= 1'b0;
         SLEEP_REQ <= 1'b0;
         WDOG_CLR  <= 1'b0;
         for (int i = 0; i < 16; i++)
            gpr_q[i] <= 8'h00;
      end
      else if (CLKEN)
      begin
         BREAK_EVT <= exec_go && op_q == OP_BREAK;
         SLEEP_REQ <= exec_go && op_q == OP_SLEEP;
         WDOG_CLR  <= exec_go && op_q == OP_WDR;
         if (busy)
         begin
            flags_q <= flags_d;
            sp_q   <= sp_d;
            if (gpr_we)
               gpr_q[rd_q] <= gpr_wd;
         end
         else if (wr_ok)
         begin
            if (hit_flags) flags_q <= PWDATA[7:0];
            if (hit_ptr)
            begin
               z_q  <= PWDATA[`CPUXB_PTR_Z_LSB +: 8];
               sp_q <= PWDATA[`CPUXB_PTR_SP_LSB +: 8];
            end
            if (hit_gpr) gpr_q[gpr_idx] <= PWDATA[7:0];
         end
         if (wr_ok && hit_ctrl)
            wait_q <= PWDATA[1:0];
      end
   end

   cpuxb_dmem u_dmem (
      .clk  (CLOCK),
      .port (mem_if.mem)
   );

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SRST);

   io_read_a: assert property (exec_go && op_q == OP_IO_READ |=>
      gpr_q[$past(rd_q)] == $past(md) && flags_q == $past(flags_q) && !busy)
      else $error("io read result or flags wrong");
   push_wr_a: assert property (exec_go && op_q == OP_PUSH |->
      mem_if.we && mem_if.waddr == sp_q && mem_if.wdata == rv && flags_d == flags_q)
      else $error("push write wrong");
   pop_len_a: assert property (acc_go && cmd_op == OP_POP |=>
      busy && step_q == 4'(4'h1 + {2'h0, wait_q}))
      else $error("pop length wrong");
   ld_or_a: assert property (exec_go && op_q == OP_LD_OR |->
      mem_if.wdata == (rv | md) ##1 gpr_q[$past(rd_q)] == $past(md))
      else $error("load-or wrong");
   ld_andn_a: assert property (exec_go && op_q == OP_LD_ANDN |->
      mem_if.we && mem_if.wdata == (md & ~rv))
      else $error("load-andnot wrong");
   ld_xor_a: assert property (exec_go && op_q == OP_LD_XOR |->
      mem_if.we && mem_if.wdata == (rv ^ md))
      else $error("load-xor wrong");
   rot_left_a: assert property (exec_go && op_q == OP_ROT_L |=>
      gpr_q[$past(rd_q)] == {$past(rv[6:0]), $past(flags_q[`CPUXB_FLG_C])}
      && flags_q[`CPUXB_FLG_C] == $past(rv[7]))
      else $error("rotate left wrong");
   rot_right_a: assert property (exec_go && op_q == OP_ROT_R |=>
      $stable(flags_q[`CPUXB_FLG_H]) && flags_q[`CPUXB_FLG_C] == $past(rv[0]))
      else $error("rotate right flags wrong");
   bit_set_a: assert property (exec_go && op_q == OP_IOB_SET |->
      mem_if.wdata[bit_q] && (mem_if.wdata | bmask) == (md | bmask))
      else $error("io bit set wrong");
   flag_set_a: assert property (exec_go && op_q == OP_FSET |=>
      flags_q == ($past(flags_q) | $past(bmask)))
      else $error("flag set wrong");

   exch_cov: cover property (exec_go && op_q == OP_EXCHG);
   wait_cov: cover property (acc_go && cmd_op == OP_PUSH && wait_q != 2'h0);
   blk_cov: cover property (apb_wr && wr_blk);
endmodule // cpuxb_core
`default_nettype wire

// [sim/cpu_transfer_bit_ops_tb.sv]
`include "cpuxb_map.svh"
`default_nettype none
module cpu_transfer_bit_ops_tb
   import cpuxb_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic        CLOCK = 1'b0;
   logic        SRST = 1'b1;
   logic        CLKEN = 1'b1;
   logic        PSEL = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic        PREADY;
   logic        PSLVERR;
   logic        BREAK_EVT;
   logic        SLEEP_REQ;
   logic        WDOG_CLR;
   logic        BUSY;
   int          bad_count = 0;
   int          num_checks = 0;
   int          pc[3] = '{0, 0, 0};
   int          ec[3] = '{0, 0, 0};
   logic [31:0] seed = 32'd58;
   cpuxb_byte_t g[16];
   cpuxb_byte_t m[256];
   cpuxb_byte_t sr;
   cpuxb_byte_t z;
   cpuxb_byte_t sp;
   logic [1:0]  wt;

   cpuxb_core dut (.CLOCK(CLOCK), .SRST(SRST), .CLKEN(CLKEN), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BREAK_EVT(BREAK_EVT),
      .SLEEP_REQ(SLEEP_REQ), .WDOG_CLR(WDOG_CLR), .BUSY(BUSY));

   initial
   begin
      forever #5 CLOCK = ~CLOCK;
   end

   always @(posedge CLOCK)
   begin
      if (BREAK_EVT === 1'b1) pc[0]++;
      if (SLEEP_REQ === 1'b1) pc[1]++;
      if (WDOG_CLR === 1'b1) pc[2]++;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic tmo();
      bad_count++;
      $display("mismatch %0t wait ran out", $time);
      stop_test();
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one setup cycle, access held until pready, idle cycle before each setup
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int i;
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      for (i = 0; i < 40; i++)
      begin
         @(posedge CLOCK);
         if (PREADY === 1'b1) break;
      end
      if (i == 40) tmo();
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      cmp(r, exp, "read data");
   endtask

   // reference step, returns expected length in cycles
   function automatic int model(logic [4:0] op, logic [2:0] b, logic [3:0] r, logic [7:0] a);
      cpuxb_byte_t v;
      cpuxb_byte_t t;
      logic        c;
      logic        sh;
      int          len;
      v = g[r];
      c = sr[`CPUXB_FLG_C];
      sh = 1'b0;
      len = 1;
      case (op)
         OP_IO_READ: g[r] = m[a];
         OP_IO_WRITE: m[a] = v;
         OP_PUSH:
         begin
            m[sp] = v;
            sp--;
            len = 1 + wt;
         end
         OP_POP:
         begin
            sp++;
            g[r] = m[sp];
            len = 2 + wt;
         end
         OP_EXCHG, OP_LD_OR, OP_LD_ANDN, OP_LD_XOR:
         begin
            t = m[z];
            g[r] = t;
            m[z] = op == OP_EXCHG ? v : op == OP_LD_OR ? v | t : op == OP_LD_ANDN ? t & ~v : v ^ t;
            len = 2 + wt;
         end
         OP_LSL, OP_ROT_L:
         begin
            t = {v[6:0], op == OP_ROT_L && c};
            sr[`CPUXB_FLG_H] = v[3];
            sr[`CPUXB_FLG_C] = v[7];
            sh = 1'b1;
         end
         OP_LSR, OP_ROT_R, OP_ASR:
         begin
            t = {op == OP_ROT_R ? c : op == OP_ASR && v[7], v[7:1]};
            sr[`CPUXB_FLG_C] = v[0];
            sh = 1'b1;
         end
         OP_SWAP: g[r] = {v[3:0], v[7:4]};
         OP_FSET: sr[b] = 1'b1;
         OP_FCLR: sr[b] = 1'b0;
         OP_IOB_SET: m[a][b] = 1'b1;
         OP_IOB_CLR: m[a][b] = 1'b0;
         OP_T_STORE: sr[`CPUXB_FLG_T] = v[b];
         OP_T_LOAD: g[r][b] = sr[`CPUXB_FLG_T];
         OP_BREAK: ec[0]++;
         OP_SLEEP: ec[1]++;
         OP_WDR: ec[2]++;
         default: ;
      endcase
      if (sh)
      begin
         g[r] = t;
         sr[`CPUXB_FLG_Z] = t == 8'h00;
         sr[`CPUXB_FLG_N] = t[7];
         sr[`CPUXB_FLG_V] = t[7] ^ sr[`CPUXB_FLG_C];
      end
      return len;
   endfunction

   // probe: a register write while busy must be refused
   task automatic cmd(input logic [4:0] op, input logic [2:0] b, input logic [3:0] r,
                      input logic [7:0] a, input bit probe);
      logic [31:0] d;
      logic        e;
      int          n;
      int          i;
      int          len;
      len = model(op, b, r, a);
      apb(1'b1, `CPUXB_OFS_CMD, {12'h0, a, r, b, op}, d, e);
      if (probe)
      begin
         apb(1'b1, {2'b01, r, 2'b00}, 32'h5a, d, e);
         cmp(e, 1'b1, "busy write not refused");
      end
      n = 0;
      for (i = 0; i < 20; i++)
      begin
         #1;
         if (BUSY !== 1'b1) break;
         n++;
         @(posedge CLOCK);
      end
      if (i == 20) tmo();
      if (!probe) cmp(n, len, "busy cycles");
      rd(`CPUXB_OFS_STAT, len << 8);
      rd(`CPUXB_OFS_CMD, {12'h0, a, r, b, op});
      rd(`CPUXB_OFS_FLAGS, sr);
      rd(`CPUXB_OFS_PTR, {sp, z});
      rd({2'b01, r, 2'b00}, g[r]);
   endtask

   initial
   begin
      #900us;
      tmo();
   end

   initial
   begin
      logic [31:0] d;
      logic        e;
      int          i;
      repeat (10) @(posedge CLOCK);
      SRST <= 1'b0;
      sr = `CPUXB_FLAGS_RST;
      sp = `CPUXB_SP_RST;
      z = `CPUXB_Z_RST;
      wt = `CPUXB_WAIT_RST;
      rd(`CPUXB_OFS_FLAGS, 32'h0);
      rd(`CPUXB_OFS_PTR, 32'hff00);
      rd(`CPUXB_OFS_CTRL, 32'h0);
      apb(1'b0, 8'h20, 32'h0, d, e);
      cmp(e, 1'b1, "unmapped not refused");
      cmp(d, 32'h0, "unmapped data");
      for (i = 0; i < 16; i++)
      begin
         g[i] = 8'(rnd());
         wr({2'b01, i[3:0], 2'b00}, {24'h0, g[i]});
      end
      // every byte written so later reads have known contents
      for (i = 0; i < 256; i++)
      begin
         g[0] = 8'(rnd());
         wr(`CPUXB_OFS_GPR, {24'h0, g[0]});
         cmd(OP_IO_WRITE, 3'h0, 4'h0, i[7:0], 1'b0);
      end
      for (i = 0; i < 8; i++)
      begin
         cmd(OP_FSET, i[2:0], 4'h1, 8'h00, 1'b0);
         cmd(OP_FCLR, i[2:0], 4'h1, 8'h00, 1'b0);
      end
      wt = 2'h3;
      wr(`CPUXB_OFS_CTRL, 32'h3);
      cmd(OP_POP, 3'h0, 4'h2, 8'h00, 1'b1);
      cmd(OP_PUSH, 3'h0, 4'h2, 8'h00, 1'b0);
      for (i = 0; i < 400; i++)
      begin
         if (rnd() % 8 == 0)
         begin
            z = 8'(rnd());
            sp = 8'(rnd());
            wt = 2'(rnd());
            g[i % 16] = 8'(rnd());
            wr(`CPUXB_OFS_PTR, {16'h0, sp, z});
            wr(`CPUXB_OFS_CTRL, {30'h0, wt});
            wr({2'b01, i[3:0], 2'b00}, {24'h0, g[i % 16]});
         end
         // frozen clock enable must leave every register untouched
         if (i % 100 == 50)
         begin
            CLKEN <= 1'b0;
            repeat (4) @(posedge CLOCK);
            cmp(PREADY, 1'b0, "ready while frozen");
            CLKEN <= 1'b1;
         end
         d = rnd();
         cmd(5'(d % 26), d[7:5], d[11:8], d[19:12], 1'b0);
      end
      for (i = 0; i < 256; i++)
         cmd(OP_IO_READ, 3'h0, 4'h1, i[7:0], 1'b0);
      for (i = 0; i < 3; i++)
         cmp(pc[i], ec[i], "event pulses");
      stop_test();
   end
endmodule // cpu_transfer_bit_ops_tb
`default_nettype wire
